// >>> core/pmt_pkg.sv
// Purpose: Shared constants for the port message termination and timeout block
// Assumes: 25 MHz system clock, eight module ports, AXI4-Lite register access
// Notes: Byte offsets are word aligned; port registers sit in 8-word windows
package pmt_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 3;
  localparam int BYTE_W = 8;
  localparam int TOUT_W = 16;
  localparam int TERM_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Timing
  localparam int CLK_PERIOD_NS = 32'h0000_0028;
  localparam int TICK_PERIOD_NS = 32'h000F_4240;
  localparam int MS_TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 16;
  localparam logic [TOUT_W-1:0] TOUT_DEFAULT_MS = 16'h03E8;
  localparam logic [TOUT_W-1:0] TOUT_ZERO = 16'h0000;
  // Termination selector codes
  localparam logic [TERM_W-1:0] TERM_CR = 3'h0;
  localparam logic [TERM_W-1:0] TERM_LF = 3'h1;
  localparam logic [TERM_W-1:0] TERM_CRLF = 3'h2;
  localparam logic [TERM_W-1:0] TERM_LFCR = 3'h3;
  localparam logic [TERM_W-1:0] TERM_NONE = 3'h4;
  localparam logic [BYTE_W-1:0] CH_CR = 8'h0D;
  localparam logic [BYTE_W-1:0] CH_LF = 8'h0A;
  localparam logic [NUM_PORTS-1:0] PORT_ONE = 8'h01;
  // Register map
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_CONN = 8'h04;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] A_HOST_TERM = 8'h10;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h14;
  localparam logic [ADDR_W-1:0] A_TOUT_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] A_TERM_BASE = 8'h40;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int IDX_HI = 4;
  localparam int IDX_LO = 2;
  // Control register bits
  localparam int CTRL_LFEOI = 0;
  localparam int CTRL_EOICV = 1;
  localparam int CTRL_CONN = 2;
  localparam int CTRL_RSTCMD = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {P_IDLE, P_DATA, P_TERM, P_DROP} port_state_t;
  typedef enum {H_IDLE, H_OUT, H_TERM} host_state_t;

  function automatic logic [1:0] term_len(input logic [TERM_W-1:0] sel);
    case (sel)
      TERM_CR, TERM_LF: term_len = 2'h1;
      TERM_CRLF, TERM_LFCR: term_len = 2'h2;
      default: term_len = 2'h0;
    endcase
  endfunction : term_len

  function automatic logic [BYTE_W-1:0] term_char(input logic [TERM_W-1:0] sel,
                                                 input logic idx);
    if (!idx)
      term_char = (sel == TERM_CR || sel == TERM_CRLF) ? CH_CR : CH_LF;
    else
      term_char = (sel == TERM_CRLF) ? CH_LF : CH_CR;
  endfunction : term_char
endpackage : pmt_pkg

// >>> core/port_msg_term_timeout.sv
// Purpose: Port message termination, output queue timeout and connect-mode EOI
// Assumes: i_port_full already accounts for a write issued the cycle before
// Notes: Summary of operation below; registers over AXI4-Lite
//
// Summary of operation
// (RULE1) Nonzero timeout: keep retrying a full port queue at most that many ms.
// (RULE2) Timeout expiry before the byte is queued sets that port's status bit.
// (RULE3) Timeout zero: wait forever on a full port queue.
// (RULE4) Reset loads every port timeout with 1000 ms.
// (RULE5) Terminator codes: CR 0, LF 1, CRLF 2, LFCR 3, none 4.
// (RULE6) Terminated sends and broadcasts get CR/LF bytes in selector order.
// (RULE7) RS-232 host: query responses end with the host port terminator.
// (RULE8) GPIB host: query responses always end with LF plus EOI.
// (RULE9) Power-on sets port terminators to LF; reset command sets CR.
// (RULE10) RS-232 host: host terminator CRLF at power-on and reset command.
// (RULE11) Connect mode, EOI-on-LF on: EOI with every LF from the port.
// (RULE12) EOI-on-LF setting: 0 off, 1 on, on after reset.
// (RULE13) Connect mode, conversion on: host EOI sends an extra LF to port.
// (RULE14) EOI conversion setting: 0 off, 1 on, on after reset.
// (RULE15) Both EOI settings have no effect with an RS-232 host.
// (RULE16) Timeouts count a free-running 1 ms tick, restarted per blocked byte.
`timescale 1ns/1ps
module port_msg_term_timeout #(
  parameter int TICK_CYCLES = pmt_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host interface type strap
  input wire logic i_host_is_rs232,
  // AXI4-Lite slave
  input wire logic i_s_axi_awvalid,
  input wire logic [pmt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  output logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic [pmt_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_wready,
  output logic o_s_axi_bvalid,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic [pmt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_arready,
  output logic o_s_axi_rvalid,
  output logic [pmt_pkg::DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_s_axi_rready,
  // Port message source (send or broadcast commands)
  input wire logic i_msg_valid,
  input wire logic [pmt_pkg::BYTE_W-1:0] i_msg_data,
  input wire logic [pmt_pkg::PORT_W-1:0] i_msg_port,
  input wire logic i_msg_last,
  input wire logic i_msg_term,
  output logic o_msg_ready,
  // Connect mode, bytes received from the host
  input wire logic i_hrx_valid,
  input wire logic [pmt_pkg::BYTE_W-1:0] i_hrx_data,
  input wire logic i_hrx_eoi,
  output logic o_hrx_ready,
  // Port output queues
  input wire logic [pmt_pkg::NUM_PORTS-1:0] i_port_full,
  output logic o_port_wr,
  output logic [pmt_pkg::BYTE_W-1:0] o_port_data,
  output logic [pmt_pkg::PORT_W-1:0] o_port_num,
  // Query responses
  input wire logic i_resp_valid,
  input wire logic [pmt_pkg::BYTE_W-1:0] i_resp_data,
  input wire logic i_resp_last,
  output logic o_resp_ready,
  // Connect mode, bytes received from the connected port
  input wire logic i_crx_valid,
  input wire logic [pmt_pkg::BYTE_W-1:0] i_crx_data,
  output logic o_crx_ready,
  // Host transmit
  output logic o_host_valid,
  output logic [pmt_pkg::BYTE_W-1:0] o_host_data,
  output logic o_host_eoi,
  input wire logic i_host_ready,
  // Interrupt
  output logic o_irq
);
  import pmt_pkg::*;

  // Registers
  logic lfeoi_r, eoicv_r, conn_r, init_r, irq_r;
  logic [PORT_W-1:0] conn_port_r;
  logic [NUM_PORTS-1:0] stat_r, mask_r;
  logic [TERM_W-1:0] host_term_r;
  logic [TOUT_W-1:0] tout_r [NUM_PORTS];
  logic [TERM_W-1:0] term_r [NUM_PORTS];
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic tick_r;

  // AXI state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_got_r, w_got_r;
  logic [1:0] bresp_r, rresp_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;

  // Port engine state
  port_state_t p_state_r, p_nxt;
  logic [BYTE_W-1:0] slot_data_r, port_data_r;
  logic [PORT_W-1:0] slot_port_r, port_num_r;
  logic [TERM_W-1:0] slot_sel_r;
  logic slot_last_r, term_idx_r, port_wr_r, msg_ready_r, hrx_ready_r;
  logic [TOUT_W-1:0] wait_ms_r;

  // Host engine state
  host_state_t h_state_r, h_nxt;
  logic [TERM_W-1:0] h_sel_r;
  logic h_last_r, h_idx_r, host_valid_r, host_eoi_r, resp_ready_r, crx_ready_r;
  logic [BYTE_W-1:0] host_data_r;

  // Bus decode
  wire aw_take = i_s_axi_awvalid & awready_r;
  wire w_take = i_s_axi_wvalid & wready_r;
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  wire aw_got_n = (aw_got_r | aw_take) & ~wr_fire;
  wire w_got_n = (w_got_r | w_take) & ~wr_fire;
  wire bvalid_n = (bvalid_r & ~i_s_axi_bready) | wr_fire;
  wire ar_take = i_s_axi_arvalid & arready_r;
  wire rvalid_n = (rvalid_r & ~i_s_axi_rready) | ar_take;
  wire [PORT_W-1:0] wa_idx = aw_addr_r[IDX_HI:IDX_LO];
  wire [PORT_W-1:0] ra_idx = i_s_axi_araddr[IDX_HI:IDX_LO];
  wire wa_tout = aw_addr_r[SEL_HI:SEL_LO] == A_TOUT_BASE[SEL_HI:SEL_LO];
  wire wa_term = aw_addr_r[SEL_HI:SEL_LO] == A_TERM_BASE[SEL_HI:SEL_LO];
  wire ra_tout = i_s_axi_araddr[SEL_HI:SEL_LO] == A_TOUT_BASE[SEL_HI:SEL_LO];
  wire ra_term = i_s_axi_araddr[SEL_HI:SEL_LO] == A_TERM_BASE[SEL_HI:SEL_LO];
  wire wr_lo = wr_fire & w_strb_r[0];
  wire wr_ctrl = wr_lo & (aw_addr_r == A_CTRL);
  wire wr_conn = wr_lo & (aw_addr_r == A_CONN);
  wire wr_stat = wr_lo & (aw_addr_r == A_STAT);
  wire wr_mask = wr_lo & (aw_addr_r == A_MASK);
  wire wr_hterm = wr_lo & (aw_addr_r == A_HOST_TERM);
  wire wr_ok = wa_tout | wa_term | (aw_addr_r == A_CTRL) | (aw_addr_r == A_CONN) |
               (aw_addr_r == A_STAT) | (aw_addr_r == A_MASK) |
               (aw_addr_r == A_HOST_TERM) | (aw_addr_r == A_STATE);
  wire rstcmd = wr_ctrl & w_data_r[CTRL_RSTCMD];
  wire gpib = ~i_host_is_rs232;

  // Port engine decode
  wire msg_take = msg_ready_r & i_msg_valid;
  wire hrx_take = hrx_ready_r & i_hrx_valid;
  wire p_active = (p_state_r == P_DATA) | (p_state_r == P_TERM);
  wire cur_full = i_port_full[slot_port_r];
  wire [TOUT_W-1:0] tout_cur = tout_r[slot_port_r];
  wire blocked = p_active & cur_full;
  wire expire = blocked & (tout_cur != TOUT_ZERO) & (wait_ms_r >= tout_cur);
  wire can_wr = p_active & ~cur_full;
  wire [1:0] slot_len = term_len(slot_sel_r);
  wire term_done = ({1'b0, term_idx_r} + 2'h1) == slot_len;
  wire [BYTE_W-1:0] cur_byte = (p_state_r == P_TERM) ?
                               term_char(slot_sel_r, term_idx_r) : slot_data_r;
  wire [TERM_W-1:0] msg_sel = i_msg_term ? term_r[i_msg_port] : TERM_NONE;
  wire [TERM_W-1:0] hrx_sel = (i_hrx_eoi & eoicv_r & gpib) ? TERM_LF : TERM_NONE;
  wire [NUM_PORTS-1:0] exp_vec = {NUM_PORTS{expire}} & (PORT_ONE << slot_port_r);
  wire [NUM_PORTS-1:0] stat_nxt = (stat_r & ~({NUM_PORTS{wr_stat}} &
                                   w_data_r[NUM_PORTS-1:0])) | exp_vec;

  // Host engine decode
  wire resp_take = resp_ready_r & i_resp_valid;
  wire crx_take = crx_ready_r & i_crx_valid;
  wire h_acc = host_valid_r & i_host_ready;
  wire [1:0] h_len = term_len(h_sel_r);
  wire h_term_done = ({1'b0, h_idx_r} + 2'h1) == h_len;
  wire [TERM_W-1:0] resp_sel = gpib ? TERM_LF : host_term_r;
  wire crx_eoi = gpib & lfeoi_r & (i_crx_data == CH_LF);

  // Read mux
  wire [DATA_W-1:0] rd_data =
    (i_s_axi_araddr == A_CTRL) ? {29'h0, conn_r, eoicv_r, lfeoi_r} :
    (i_s_axi_araddr == A_CONN) ? {29'h0, conn_port_r} :
    (i_s_axi_araddr == A_STAT) ? {24'h0, stat_r} :
    (i_s_axi_araddr == A_MASK) ? {24'h0, mask_r} :
    (i_s_axi_araddr == A_HOST_TERM) ? {29'h0, host_term_r} :
    (i_s_axi_araddr == A_STATE) ? {29'h0, i_host_is_rs232, p_active, blocked} :
    ra_tout ? {16'h0, tout_r[ra_idx]} :
    ra_term ? {29'h0, term_r[ra_idx]} : 32'h0000_0000;
  wire rd_ok = ra_tout | ra_term | (i_s_axi_araddr == A_CTRL) |
               (i_s_axi_araddr == A_CONN) | (i_s_axi_araddr == A_STAT) |
               (i_s_axi_araddr == A_MASK) | (i_s_axi_araddr == A_HOST_TERM) |
               (i_s_axi_araddr == A_STATE);

  // AXI write channel
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_got_r <= 1'b0; w_got_r <= 1'b0; awready_r <= 1'b0; wready_r <= 1'b0;
      bvalid_r <= 1'b0; bresp_r <= RESP_OKAY; aw_addr_r <= '0; w_data_r <= '0;
      w_strb_r <= '0;
    end
    else
    begin
      aw_got_r <= aw_got_n; w_got_r <= w_got_n;
      awready_r <= ~aw_got_n; wready_r <= ~w_got_n; bvalid_r <= bvalid_n;
      if (aw_take) aw_addr_r <= i_s_axi_awaddr;
      if (w_take) w_data_r <= i_s_axi_wdata;
      if (w_take) w_strb_r <= i_s_axi_wstrb;
      if (wr_fire) bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // AXI read channel, answer one cycle after the address is taken
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      arready_r <= 1'b0; rvalid_r <= 1'b0; rdata_r <= '0; rresp_r <= RESP_OKAY;
    end
    else
    begin
      arready_r <= ~rvalid_n; rvalid_r <= rvalid_n;
      if (ar_take) rdata_r <= rd_data;
      if (ar_take) rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Control, status, mask and host terminator
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lfeoi_r <= 1'b1; eoicv_r <= 1'b1; conn_r <= 1'b0; conn_port_r <= '0; // [RULE12] [RULE14]
      stat_r <= '0; mask_r <= '0; irq_r <= 1'b0; init_r <= 1'b1;
      host_term_r <= TERM_LF; // [RULE9]
    end
    else
    begin
      init_r <= 1'b0;
      stat_r <= stat_nxt; // [RULE2]
      irq_r <= |(stat_nxt & mask_r);
      if (wr_mask) mask_r <= w_data_r[NUM_PORTS-1:0];
      if (wr_conn) conn_port_r <= w_data_r[PORT_W-1:0];
      if (rstcmd)
      begin
        lfeoi_r <= 1'b1; eoicv_r <= 1'b1; conn_r <= 1'b0; // [RULE12] [RULE14]
      end
      else if (wr_ctrl)
      begin
        lfeoi_r <= w_data_r[CTRL_LFEOI]; eoicv_r <= w_data_r[CTRL_EOICV];
        conn_r <= w_data_r[CTRL_CONN];
      end
      // Strap caught on the first edge after release
      if (init_r | rstcmd)
        host_term_r <= i_host_is_rs232 ? TERM_CRLF : (rstcmd ? TERM_CR : host_term_r); // [RULE10]
      else if (wr_hterm)
        host_term_r <= w_data_r[TERM_W-1:0];
    end
  end

  // Per-port timeout and terminator settings
  for (genvar g = 0; g < NUM_PORTS; g++)
  begin : g_port
    wire sel_me = wa_idx == PORT_W'(g);
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
      begin
        tout_r[g] <= TOUT_DEFAULT_MS; // [RULE4]
        term_r[g] <= TERM_LF; // [RULE9]
      end
      else if (rstcmd)
      begin
        tout_r[g] <= TOUT_DEFAULT_MS; // [RULE4]
        term_r[g] <= TERM_CR; // [RULE9]
      end
      else
      begin
        if (wr_fire & wa_tout & sel_me & w_strb_r[0]) tout_r[g][7:0] <= w_data_r[7:0];
        if (wr_fire & wa_tout & sel_me & w_strb_r[1]) tout_r[g][15:8] <= w_data_r[15:8];
        if (wr_lo & wa_term & sel_me) term_r[g] <= w_data_r[TERM_W-1:0]; // [RULE5]
      end
    end
  end

  // Free-running millisecond tick
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt_r <= '0; tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1); // [RULE16]
      tick_cnt_r <= (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Port engine next state
  always_comb
  begin
    p_nxt = p_state_r;
    case (p_state_r)
      P_IDLE: if (msg_take | hrx_take) p_nxt = P_DATA;
      P_DATA:
        if (can_wr) p_nxt = (slot_last_r & (slot_len != 2'h0)) ? P_TERM : P_IDLE; // [RULE6]
        else if (expire) p_nxt = slot_last_r ? P_IDLE : P_DROP; // [RULE1]
      P_TERM:
        if (can_wr) p_nxt = term_done ? P_IDLE : P_TERM;
        else if (expire) p_nxt = P_IDLE;
      P_DROP: if (msg_take & i_msg_last) p_nxt = P_IDLE;
      default: p_nxt = P_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      p_state_r <= P_IDLE; slot_data_r <= '0; slot_port_r <= '0; slot_sel_r <= TERM_NONE;
      slot_last_r <= 1'b0; term_idx_r <= 1'b0; wait_ms_r <= '0;
      msg_ready_r <= 1'b0; hrx_ready_r <= 1'b0;
      port_wr_r <= 1'b0; port_data_r <= '0; port_num_r <= '0;
    end
    else
    begin
      p_state_r <= p_nxt;
      msg_ready_r <= ((p_nxt == P_IDLE) & ~conn_r) | (p_nxt == P_DROP);
      hrx_ready_r <= (p_nxt == P_IDLE) & conn_r;
      if ((p_state_r == P_IDLE) & (msg_take | hrx_take))
      begin
        slot_data_r <= msg_take ? i_msg_data : i_hrx_data;
        slot_port_r <= msg_take ? i_msg_port : conn_port_r;
        slot_last_r <= msg_take ? i_msg_last : 1'b1;
        slot_sel_r <= msg_take ? msg_sel : hrx_sel; // [RULE6] [RULE13] [RULE15]
      end
      term_idx_r <= (p_state_r == P_TERM) ? term_idx_r ^ can_wr : 1'b0;
      // Restarted for each blocked byte; zero setting never expires
      wait_ms_r <= ~blocked ? '0 : wait_ms_r + {15'h0, tick_r & ~expire}; // [RULE16] [RULE3]
      port_wr_r <= can_wr;
      if (can_wr) port_data_r <= cur_byte;
      if (can_wr) port_num_r <= slot_port_r;
    end
  end

  // Host engine next state
  always_comb
  begin
    h_nxt = h_state_r;
    case (h_state_r)
      H_IDLE: if (resp_take | crx_take) h_nxt = H_OUT;
      H_OUT: if (h_acc) h_nxt = (h_last_r & (h_len != 2'h0)) ? H_TERM : H_IDLE; // [RULE7]
      H_TERM: if (h_acc & h_term_done) h_nxt = H_IDLE;
      default: h_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      h_state_r <= H_IDLE; h_sel_r <= TERM_NONE; h_last_r <= 1'b0; h_idx_r <= 1'b0;
      host_valid_r <= 1'b0; host_data_r <= '0; host_eoi_r <= 1'b0;
      resp_ready_r <= 1'b0; crx_ready_r <= 1'b0;
    end
    else
    begin
      h_state_r <= h_nxt;
      resp_ready_r <= (h_nxt == H_IDLE) & ~conn_r;
      crx_ready_r <= (h_nxt == H_IDLE) & conn_r;
      if ((h_state_r == H_IDLE) & (resp_take | crx_take))
      begin
        host_valid_r <= 1'b1;
        host_data_r <= resp_take ? i_resp_data : i_crx_data;
        host_eoi_r <= crx_take & crx_eoi; // [RULE11] [RULE15]
        h_last_r <= resp_take & i_resp_last;
        h_sel_r <= resp_sel; // [RULE7] [RULE8]
        h_idx_r <= 1'b0;
      end
      else if (h_acc & (h_nxt == H_TERM))
      begin
        host_data_r <= term_char(h_sel_r, h_idx_r ^ (h_state_r == H_TERM));
        host_eoi_r <= gpib & (h_state_r == H_OUT ? h_len == 2'h1 : 1'b1); // [RULE8]
        h_idx_r <= h_state_r == H_TERM;
      end
      else if (h_acc)
      begin
        host_valid_r <= 1'b0; host_eoi_r <= 1'b0;
      end
    end
  end

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready = wready_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_msg_ready = msg_ready_r;
  assign o_hrx_ready = hrx_ready_r;
  assign o_port_wr = port_wr_r;
  assign o_port_data = port_data_r;
  assign o_port_num = port_num_r;
  assign o_resp_ready = resp_ready_r;
  assign o_crx_ready = crx_ready_r;
  assign o_host_valid = host_valid_r;
  assign o_host_data = host_data_r;
  assign o_host_eoi = host_eoi_r;
  assign o_irq = irq_r;

  // Checks
  a_wait_bounded: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE1]
    (blocked && tout_cur != TOUT_ZERO) |-> wait_ms_r <= tout_cur)
    else $error("wait exceeded timeout");
  property p_expire_flags;
    logic [PORT_W-1:0] p;
    @(posedge i_mclk) disable iff (i_rst) (expire, p = slot_port_r) |=> stat_r[p];
  endproperty
  a_expire_sets_stat: assert property (p_expire_flags) // [RULE2]
    else $error("timeout not recorded");
  a_zero_never_expires: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE3]
    (tout_cur == TOUT_ZERO) |-> !expire)
    else $error("zero timeout expired");
  a_reset_defaults: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE4]
    $past(i_rst) |-> (tout_r[0] == TOUT_DEFAULT_MS && lfeoi_r && eoicv_r))
    else $error("reset defaults wrong");
  a_rstcmd_term_cr: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE9]
    rstcmd |=> (term_r[0] == TERM_CR && tout_r[NUM_PORTS-1] == TOUT_DEFAULT_MS))
    else $error("reset command defaults wrong");
  a_term_bytes_crlf: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE6]
    (p_state_r == P_TERM && can_wr) |=> (o_port_wr && (o_port_data == CH_CR ||
     o_port_data == CH_LF)))
    else $error("bad terminator byte");
  a_gpib_resp_lf_eoi: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE8]
    (h_state_r == H_TERM && gpib && $past(gpib, 2)) |-> (o_host_eoi && o_host_data == CH_LF))
    else $error("gpib response not LF-EOI");
  a_conn_lf_eoi: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE11]
    (crx_take && h_state_r == H_IDLE && crx_eoi) |=> (o_host_valid && o_host_eoi))
    else $error("missing EOI on LF");
  a_eoicv_adds_lf: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE13]
    (hrx_take && p_state_r == P_IDLE && i_hrx_eoi && eoicv_r && gpib) |=> slot_sel_r == TERM_LF)
    else $error("EOI not converted");
  a_rs232_no_eoi: assert property (@(posedge i_mclk) disable iff (i_rst) // [RULE15]
    (i_host_is_rs232 && $past(i_host_is_rs232, 2) && o_host_valid) |-> !o_host_eoi)
    else $error("EOI on RS-232 host");
  c_timeout: cover property (@(posedge i_mclk) disable iff (i_rst) expire);
  c_term_two: cover property (@(posedge i_mclk) disable iff (i_rst)
    (p_state_r == P_TERM && can_wr && term_idx_r));
  c_conn_eoi: cover property (@(posedge i_mclk) disable iff (i_rst) o_host_valid && o_host_eoi);
endmodule : port_msg_term_timeout

// >>> testbench/host_sink.sv
// Purpose: Host side byte sink for the host transmit stream
// Assumes: Accepts bytes on alternate cycles only
// Notes: Stalls on purpose so held bytes are exercised
`timescale 1ns/1ps
module host_sink (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host byte stream
  input wire logic i_valid,
  output logic o_ready
);
  logic ready_r;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ready_r <= 1'b0;
    else
      ready_r <= i_valid ? ~ready_r : 1'b0;
  end
  assign o_ready = ready_r;
endmodule : host_sink

// >>> testbench/port_msg_term_timeout_tb.sv
// Purpose: Self-checking bench for port termination, timeout and host paths
// Assumes: Small tick of 4 cycles per millisecond
// Notes: Outputs sampled at the falling edge, inputs driven at the rising edge
`timescale 1ns/1ps
module port_msg_term_timeout_tb;
  import pmt_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_host_is_rs232 = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
  logic i_s_axi_bready = 1, i_s_axi_arvalid = 0, i_s_axi_rready = 1, i_msg_valid = 0;
  logic i_msg_last = 0, i_msg_term = 0, i_hrx_valid = 0, i_hrx_eoi = 0, i_resp_valid = 0;
  logic i_resp_last = 0, i_crx_valid = 0, i_host_ready, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_msg_ready, o_hrx_ready, o_port_wr;
  logic o_resp_ready, o_crx_ready, o_host_valid, o_host_eoi, o_irq;
  logic [ADDR_W-1:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
  logic [DATA_W-1:0] i_s_axi_wdata = 0, o_s_axi_rdata, rd_v;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rd_r;
  logic [BYTE_W-1:0] i_msg_data = 0, i_hrx_data = 0, i_resp_data = 0, i_crx_data = 0;
  logic [BYTE_W-1:0] o_port_data, o_host_data;
  logic [PORT_W-1:0] i_msg_port = 0, o_port_num;
  logic [NUM_PORTS-1:0] i_port_full = 0;
  logic [8:0] hq[$];
  logic [7:0] pq[$];
  int fails = 0, num_checks = 0, cyc = 0;
  typedef struct {logic [2:0] sel; int n; logic [7:0] c0; logic [7:0] c1;} row_t;
  row_t rows[5] = '{'{TERM_CR, 1, CH_CR, 8'h00}, '{TERM_LF, 1, CH_LF, 8'h00},
    '{TERM_CRLF, 2, CH_CR, CH_LF}, '{TERM_LFCR, 2, CH_LF, CH_CR}, '{TERM_NONE, 0, 8'h00, 8'h00}};
  port_msg_term_timeout #(.TICK_CYCLES(4)) dut_u (.*);
  host_sink sink_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(o_host_valid),
    .o_ready(i_host_ready));
  initial forever #20 i_mclk = ~i_mclk;
  always @(negedge i_mclk)
  begin
    if (o_port_wr)
      pq.push_back(o_port_data);
    if (o_host_valid && i_host_ready)
      hq.push_back({o_host_eoi, o_host_data});
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_s_axi_awvalid, i_s_axi_wvalid} <= 2'h3;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    do @(negedge i_mclk);
    while (!(o_s_axi_awready && o_s_axi_wready));
    @(posedge i_mclk);
    {i_s_axi_awvalid, i_s_axi_wvalid} <= 2'h0;
    do @(negedge i_mclk);
    while (!o_s_axi_bvalid);
    rd_r = o_s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr <= a;
    do @(negedge i_mclk);
    while (!o_s_axi_arready);
    @(posedge i_mclk);
    i_s_axi_arvalid <= 1'b0;
    do @(negedge i_mclk);
    while (!o_s_axi_rvalid);
    rd_v = o_s_axi_rdata;
    rd_r = o_s_axi_rresp;
  endtask : rd
  task automatic push(input int k, input logic [2:0] p, input logic [7:0] d, input logic t);
    @(posedge i_mclk);
    i_msg_valid <= (k == 0);
    i_resp_valid <= (k == 1);
    i_crx_valid <= (k == 2);
    i_hrx_valid <= (k == 3);
    {i_msg_data, i_resp_data, i_crx_data, i_hrx_data} <= {4{d}};
    i_msg_port <= p;
    i_msg_term <= t;
    i_hrx_eoi <= t;
    {i_msg_last, i_resp_last} <= 2'h3;
    do @(negedge i_mclk);
    while (!(k == 0 ? o_msg_ready : k == 1 ? o_resp_ready : k == 2 ? o_crx_ready : o_hrx_ready));
    @(posedge i_mclk);
    {i_msg_valid, i_resp_valid, i_crx_valid, i_hrx_valid, i_msg_last, i_resp_last} <= 6'h00;
  endtask : push
  task automatic drv(input logic [7:0] f, input logic s);
    @(posedge i_mclk);
    i_port_full <= f;
    i_host_is_rs232 <= s;
  endtask : drv
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(A_TOUT_BASE);
    chk(rd_v, TOUT_DEFAULT_MS);
    rd(A_TERM_BASE + 8'h1C);
    chk(rd_v, TERM_LF);
    rd(A_CTRL);
    chk(rd_v, 32'h0000_0003);
    rd(8'hFC);
    chk(rd_r, RESP_SLVERR);
    wr(8'hFC, 32'h0000_0001);
    chk(rd_r, RESP_SLVERR);
    wr(A_TERM_BASE, TERM_CRLF);
    wr(A_CTRL, 32'h0000_0008);
    rd(A_TERM_BASE);
    chk(rd_v, TERM_CR);
    foreach (rows[i])
    begin
      wr(A_TERM_BASE + 8'h04, rows[i].sel);
      pq.delete();
      push(0, 3'h1, 8'h41, 1'b1);
      repeat (8) @(posedge i_mclk);
      chk(pq.size(), rows[i].n + 1);
      for (int j = 1; j < pq.size() && j < 3; j++)
        chk(pq[j], j == 1 ? rows[i].c0 : rows[i].c1);
    end
    $display("test terminators finished");
    wr(A_TOUT_BASE + 8'h0C, 32'h0000_0000);
    drv(8'h08, 1'b0);
    pq.delete();
    push(0, 3'h3, 8'h55, 1'b0);
    repeat (40) @(posedge i_mclk);
    rd(A_STAT);
    chk(rd_v, 32'h0000_0000);
    drv(8'h00, 1'b0);
    repeat (4) @(posedge i_mclk);
    chk(pq.size(), 1);
    wr(A_TOUT_BASE + 8'h08, 32'h0000_0002);
    wr(A_MASK, 32'h0000_0004);
    drv(8'h04, 1'b0);
    push(0, 3'h2, 8'h66, 1'b0);
    rd(A_STAT);
    chk(rd_v, 32'h0000_0000);
    repeat (14) @(posedge i_mclk);
    rd(A_STAT);
    chk(rd_v, 32'h0000_0004);
    chk(o_irq, 1'b1);
    drv(8'h00, 1'b0);
    wr(A_STAT, 32'h0000_0004);
    rd(A_STAT);
    chk({rd_v[2], o_irq}, 2'h0);
    $display("test timeouts finished");
    wr(A_HOST_TERM, TERM_CR);
    hq.delete();
    push(1, 3'h0, 8'h42, 1'b0);
    repeat (16) @(posedge i_mclk);
    chk({hq.size(), hq[0], hq[1]}, {32'd2, 9'h042, 1'b1, CH_LF});
    wr(A_CONN, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_0007);
    hq.delete();
    push(2, 3'h0, CH_LF, 1'b0);
    push(2, 3'h0, 8'h43, 1'b0);
    repeat (16) @(posedge i_mclk);
    chk({hq[0], hq[1]}, {1'b1, CH_LF, 9'h043});
    pq.delete();
    push(3, 3'h0, 8'h44, 1'b1);
    repeat (8) @(posedge i_mclk);
    chk({pq.size(), pq[0], pq[1], o_port_num}, {32'd2, 8'h44, CH_LF, 3'h5});
    $display("test gpib host finished");
    drv(8'h00, 1'b1);
    wr(A_CTRL, 32'h0000_0008);
    rd(A_HOST_TERM);
    chk(rd_v, TERM_CRLF);
    hq.delete();
    push(1, 3'h0, 8'h42, 1'b0);
    repeat (16) @(posedge i_mclk);
    chk({hq.size(), hq[1], hq[2]}, {32'd3, 1'b0, CH_CR, 1'b0, CH_LF});
    $display("test rs232 host finished");
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(A_HOST_TERM);
    chk(rd_v, TERM_CRLF);
    rd(A_TERM_BASE);
    chk(rd_v, TERM_LF);
    $display("test reset finished");
    print_verdict();
  end
endmodule : port_msg_term_timeout_tb
